// file: design/pmc_pkg.sv
// constants shared by the power mode controller design and its bench
// assumes a single 25 MHz clock and a 32-bit register bus
//
// Operation
// (RULE1) idle stops cpu clock, peripherals keep running
// (RULE2) idle preserves pc, status, registers, ram
// (RULE3) idle starts right after the setting write
// (RULE4) both bits set: power-down only, no idle
// (RULE5) enabled interrupt ends idle, clears idle bit
// (RULE6) reset pin in idle clears bit, restores clock
// (RULE7) ram blocked between reset wake and sequence
// (RULE8) software avoids port writes after entry
// (RULE9) power-down stops oscillator and all clocks
// (RULE10) power-down preserves pc, status, registers, ram
// (RULE11) power-down starts right after the setting write
// (RULE12) only external lines wake from power-down
// (RULE13) execution waits for external line release
// (RULE14) waking line level-sensitive, held long enough
// (RULE15) interrupt wake keeps registers and ram intact
// (RULE16) reset pin in power-down restarts all clocks
// (RULE17) reset wake reinitialises registers, keeps ram
// (RULE18) pin states per reset, idle, power-down
// (RULE19) power-down bit 1, idle bit 0, precedence
// (RULE20) power-off flag bit 4 set at power-up
// (RULE21) bits 3 and 2 are plain software flags
// (RULE22) bit 7 doubles baud, bit 6 selects top bit
// (RULE23) bits 3 to 0 clear on reset
`default_nettype none

package pmc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] POWER_CONTROL_INDEX = 12'h087;  // printed offset
    localparam logic [11:0] POWER_CONTROL_ADDR  = 12'h21C;  // index times four
    localparam logic [7:0]  POWER_CONTROL_RESET = 8'h10;    // power-up value
    localparam logic [7:0]  POWER_CONTROL_WMASK = 8'hDF;    // bit 5 reserved
    localparam logic [3:0]  POWER_CONTROL_RCLR  = 4'h0;     // pin reset value

    // ------------------------------------------------------------------
    // power control field positions
    // ------------------------------------------------------------------
    localparam int IDLE_BIT     = 0;  // idle request
    localparam int PDOWN_BIT    = 1;  // power-down request
    localparam int GFLAG_LO_BIT = 2;  // general flag low
    localparam int GFLAG_HI_BIT = 3;  // general flag high
    localparam int POFF_BIT     = 4;  // power-off flag
    localparam int FESEL_BIT    = 6;  // frame error select
    localparam int BAUD2_BIT    = 7;  // baud double

    // ------------------------------------------------------------------
    // bus answers and timing defaults
    // ------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [15:0] RESET_VEC   = 16'h0000; // core restart
    localparam int          WAKE_LAG    = 4;  // cycles before seq
    localparam int          SEQ_LEN     = 2;  // least seq cycles

    // ------------------------------------------------------------------
    // one-hot power states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_RUN   = 6'h01,  // normal execution
        ST_IDLE  = 6'h02,  // cpu clock stopped
        ST_PDOWN = 6'h04,  // oscillator stopped
        ST_PDWK  = 6'h08,  // osc on, waiting line release
        ST_RLAG  = 6'h10,  // cpu runs, ram blocked
        ST_RSEQ  = 6'h20   // internal reset sequence
    } pmc_state_e;

endpackage : pmc_pkg

`default_nettype wire

// file: design/pmc_top.sv
// power mode controller: idle and power-down sequencing, pin states
// assumes an AXI4-Lite master, and core signals synchronous to CLK
//
// Chosen here: the AXI4-Lite interface to the registers.
`default_nettype none

module pmc_top #(
    parameter int LAG_CYCLES = pmc_pkg::WAKE_LAG,  // reset wake lag
    parameter int SEQ_CYCLES = pmc_pkg::SEQ_LEN    // reset seq length
) (
    input  wire logic        CLK,
    input  wire logic        SRST,
    // axi4-lite slave
    input  wire logic [11:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [11:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // wake and reset sources
    input  wire logic        RST_PIN,
    input  wire logic        IRQ_PENDING,
    input  wire logic        EXT_IRQ_LINE_A_N,
    input  wire logic        EXT_IRQ_LINE_B_N,
    // clock enables and core control
    output logic             CPU_CLK_EN,
    output logic             PERIPH_CLK_EN,
    output logic             OSC_EN,
    output logic             RAM_BLOCK,
    output logic             CORE_RESET,
    output logic [15:0]      RESET_VECTOR,
    // pins
    input  wire logic        EXT_CODE,
    input  wire logic        CORE_P0_OE_N,
    input  wire logic        CORE_ALE,
    input  wire logic        CORE_PROG_STROBE,
    output logic             PORT0_OE_N,
    output logic             PORTS_FORCE_HIGH,
    output logic             ALE_OUT,
    output logic             PROG_STORE_STROBE,
    // serial steering
    input  wire logic        SERIAL_MODE_TOP_IN,
    input  wire logic        FRAME_ERROR_IN,
    output logic             BAUD_DOUBLE,
    output logic             SERIAL_CTRL_TOP
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    pmc_pkg::pmc_state_e state_reg;        // power state
    pmc_pkg::pmc_state_e state_next;       // its next value
    logic [7:0]          power_control_reg; // the control register
    logic [7:0]          cnt_reg;          // lag and seq counter
    logic                aw_hold_reg;      // write address held
    logic                w_hold_reg;       // write data held
    logic [11:0]         awaddr_reg;       // held write address
    logic [31:0]         wdata_reg;        // held write data
    logic [3:0]          wstrb_reg;        // held byte enables
    logic                bvalid_reg;       // write answer pending
    logic [1:0]          bresp_reg;        // write answer code
    logic                rvalid_reg;       // read answer pending
    logic [31:0]         rdata_reg;        // read data
    logic [1:0]          rresp_reg;        // read answer code
    logic                ale_reg;          // strobe pin state
    logic                program_store_strobe_reg;         // program strobe state
    logic                p0_oe_n_reg;      // port 0 float control
    logic                ports_hi_reg;     // ports forced high
    logic                wr_fire;          // write performed now
    logic                wr_power_control;          // write hits the register
    logic                ext_low;          // a wake line is low
    logic                hw_clear;         // hardware clears 1:0
    logic                low_power;        // idle or power-down

    // ------------------------------------------------------------------
    // bus write channels
    // ------------------------------------------------------------------
    assign S_AXI_AWREADY = !aw_hold_reg;
    assign S_AXI_WREADY  = !w_hold_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    // write happens once both halves are in and the answer slot is free
    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wr_power_control = wr_fire && (awaddr_reg == pmc_pkg::POWER_CONTROL_ADDR)
                     && wstrb_reg[0];

    // address and data taken in either order
    always_ff @(posedge CLK) begin
        if (SRST) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= 12'h000;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && !aw_hold_reg) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= S_AXI_AWADDR;
            end else if (wr_fire) begin
                aw_hold_reg <= 1'b0;
            end
            if (S_AXI_WVALID && !w_hold_reg) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= S_AXI_WDATA;
                wstrb_reg  <= S_AXI_WSTRB;
            end else if (wr_fire) begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    // write answer, unmapped address gets slverr
    always_ff @(posedge CLK) begin
        if (SRST) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= pmc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (awaddr_reg == pmc_pkg::POWER_CONTROL_ADDR) ?
                          pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // bus read channel
    // ------------------------------------------------------------------
    assign S_AXI_ARREADY = !rvalid_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_reg;
    assign S_AXI_RRESP   = rresp_reg;

    // one read at a time, answer one cycle after the address
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= pmc_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            if (S_AXI_ARADDR == pmc_pkg::POWER_CONTROL_ADDR) begin
                rdata_reg <= {24'h000000, power_control_reg};
                rresp_reg <= pmc_pkg::RESP_OKAY;
            end else begin
                rdata_reg <= 32'h00000000;
                rresp_reg <= pmc_pkg::RESP_SLVERR;
            end
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // power control register
    // ------------------------------------------------------------------
    assign ext_low   = !EXT_IRQ_LINE_A_N || !EXT_IRQ_LINE_B_N;
    assign low_power = (state_reg == pmc_pkg::ST_IDLE) ||
                       (state_reg == pmc_pkg::ST_PDOWN);
    // wake events clear both request bits
    assign hw_clear =
        RST_PIN ||                                          // [RULE6]
        ((state_reg == pmc_pkg::ST_IDLE) && IRQ_PENDING) || // [RULE5]
        ((state_reg == pmc_pkg::ST_PDOWN) && ext_low);      // [RULE12]

    // hardware clear beats a same-cycle software write of the bits
    always_ff @(posedge CLK) begin
        if (SRST) begin
            // srst stands for supply rise, so the off flag comes up set
            power_control_reg <= pmc_pkg::POWER_CONTROL_RESET;   // [RULE20]
        end else begin
            if (wr_power_control) begin
                // flags 3:2 are plain storage, 7:6 steer the serial outputs  [RULE21]
                power_control_reg <= wdata_reg[7:0] & pmc_pkg::POWER_CONTROL_WMASK;
            end
            if (state_reg == pmc_pkg::ST_RSEQ) begin
                // registers reinitialise, off flag survives [RULE17] [RULE23]
                power_control_reg[3:0] <= pmc_pkg::POWER_CONTROL_RCLR;
            end else if (hw_clear) begin
                power_control_reg[pmc_pkg::IDLE_BIT]  <= 1'b0; // [RULE19]
                power_control_reg[pmc_pkg::PDOWN_BIT] <= 1'b0; // [RULE4]
            end
        end
    end

    // ------------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pmc_pkg::ST_RUN: begin
                if (RST_PIN) begin
                    state_next = pmc_pkg::ST_RSEQ;
                end else if (wr_power_control &&
                             wdata_reg[pmc_pkg::PDOWN_BIT]) begin
                    // precedence over idle  [RULE4] [RULE11]
                    state_next = pmc_pkg::ST_PDOWN;
                end else if (wr_power_control &&
                             wdata_reg[pmc_pkg::IDLE_BIT]) begin
                    state_next = pmc_pkg::ST_IDLE;  // [RULE3]
                end
            end
            pmc_pkg::ST_IDLE: begin
                if (RST_PIN) begin
                    state_next = pmc_pkg::ST_RLAG;  // [RULE6]
                end else if (IRQ_PENDING) begin
                    state_next = pmc_pkg::ST_RUN;   // [RULE5]
                end
            end
            pmc_pkg::ST_PDOWN: begin
                if (RST_PIN) begin
                    state_next = pmc_pkg::ST_RLAG;  // [RULE16]
                end else if (ext_low) begin
                    state_next = pmc_pkg::ST_PDWK;  // [RULE12]
                end
            end
            pmc_pkg::ST_PDWK: begin
                // never returns to idle, only to run, or to ST_RSEQ on the reset pin  [RULE4]
                if (RST_PIN) begin
                    state_next = pmc_pkg::ST_RSEQ;
                end else if (!ext_low) begin
                    state_next = pmc_pkg::ST_RUN;   // [RULE13]
                end
            end
            pmc_pkg::ST_RLAG: begin
                if (cnt_reg == 8'(LAG_CYCLES - 1)) begin
                    state_next = pmc_pkg::ST_RSEQ;  // [RULE7]
                end
            end
            pmc_pkg::ST_RSEQ: begin
                if (!RST_PIN && cnt_reg >= 8'(SEQ_CYCLES - 1)) begin
                    state_next = pmc_pkg::ST_RUN;
                end
            end
            default: begin
                state_next = pmc_pkg::ST_RUN;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_reg <= pmc_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // lag and sequence counter, restarts on each state change
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_reg <= 8'h00;
        end else if (state_next != state_reg) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg != 8'hFF) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // clock enables and core control
    // ------------------------------------------------------------------
    // the reset pin reopens clocks without waiting for an edge,
    // standing in for the asynchronous clear of the request bits
    // frozen cpu clock keeps pc, status, registers and ram [RULE2] [RULE10]
    assign CPU_CLK_EN = (state_reg == pmc_pkg::ST_RUN) ||
                        (state_reg == pmc_pkg::ST_RLAG) ||
                        (low_power && RST_PIN);          // [RULE1] [RULE6]
    assign PERIPH_CLK_EN = (state_reg != pmc_pkg::ST_PDOWN) ||
                           RST_PIN;                      // [RULE9] [RULE16]
    assign OSC_EN = (state_reg != pmc_pkg::ST_PDOWN) ||
                    ext_low || RST_PIN;                  // [RULE12]
    // interrupt wake returns to run without reset, via ST_PDWK from power-down  [RULE15]
    assign RAM_BLOCK  = (state_reg == pmc_pkg::ST_RLAG);  // [RULE7]
    assign CORE_RESET = (state_reg == pmc_pkg::ST_RSEQ);  // [RULE16]
    assign RESET_VECTOR = pmc_pkg::RESET_VEC;

    // ------------------------------------------------------------------
    // pin states
    // ------------------------------------------------------------------
    // registered so pin levels never glitch on state decode
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ale_reg      <= 1'b1;
            program_store_strobe_reg     <= 1'b1;
            p0_oe_n_reg  <= 1'b1;
            ports_hi_reg <= 1'b1;
        end else begin
            case (state_next)
                pmc_pkg::ST_RSEQ: begin
                    // port 0 floats, others high  [RULE18]
                    ale_reg      <= 1'b1;
                    program_store_strobe_reg     <= 1'b1;
                    p0_oe_n_reg  <= 1'b1;
                    ports_hi_reg <= 1'b1;
                end
                pmc_pkg::ST_IDLE: begin
                    ale_reg      <= 1'b1;        // [RULE18]
                    program_store_strobe_reg     <= 1'b1;
                    p0_oe_n_reg  <= EXT_CODE;
                    ports_hi_reg <= 1'b0;
                end
                pmc_pkg::ST_PDOWN: begin
                    ale_reg      <= 1'b0;        // [RULE18]
                    program_store_strobe_reg     <= 1'b0;
                    p0_oe_n_reg  <= EXT_CODE;
                    ports_hi_reg <= 1'b0;
                end
                default: begin
                    // core owns the pins while it runs
                    ale_reg      <= CORE_ALE;
                    program_store_strobe_reg     <= CORE_PROG_STROBE;
                    p0_oe_n_reg  <= CORE_P0_OE_N;
                    ports_hi_reg <= 1'b0;
                end
            endcase
        end
    end

    assign ALE_OUT           = ale_reg;
    assign PROG_STORE_STROBE = program_store_strobe_reg;
    assign PORT0_OE_N        = p0_oe_n_reg;
    assign PORTS_FORCE_HIGH  = ports_hi_reg;

    // ------------------------------------------------------------------
    // serial steering
    // ------------------------------------------------------------------
    assign BAUD_DOUBLE = power_control_reg[pmc_pkg::BAUD2_BIT]; // [RULE22]
    assign SERIAL_CTRL_TOP =
        power_control_reg[pmc_pkg::FESEL_BIT] ?
        FRAME_ERROR_IN : SERIAL_MODE_TOP_IN;                     // [RULE22]

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    AST_IDLE_CLOCKS: assert property ( // [RULE1]
        state_reg == pmc_pkg::ST_IDLE && !RST_PIN |->
        PERIPH_CLK_EN && !CPU_CLK_EN)
        else $error("idle clock enables wrong");

    AST_IDLE_ENTRY: assert property ( // [RULE3]
        state_reg == pmc_pkg::ST_RUN && !RST_PIN && wr_power_control &&
        wdata_reg[1:0] == 2'h1 |=> !CPU_CLK_EN || RST_PIN)
        else $error("idle not entered after write");

    AST_PD_PRECEDENCE: assert property ( // [RULE4]
        state_reg == pmc_pkg::ST_RUN && !RST_PIN && wr_power_control &&
        wdata_reg[1:0] == 2'h3 |=> state_reg == pmc_pkg::ST_PDOWN)
        else $error("power-down lost precedence");

    AST_IDLE_WAKE: assert property ( // [RULE5]
        state_reg == pmc_pkg::ST_IDLE && IRQ_PENDING && !RST_PIN |=>
        CPU_CLK_EN && !power_control_reg[0])
        else $error("idle not left on interrupt");

    AST_RST_RESTORE: assert property ( // [RULE6]
        low_power && RST_PIN |-> CPU_CLK_EN && OSC_EN
        ##1 power_control_reg[1:0] == 2'h0)
        else $error("reset pin did not restore clocks");

    AST_RAM_BLOCK: assert property ( // [RULE7]
        $rose(RAM_BLOCK) |-> RAM_BLOCK [*4] ##1 CORE_RESET)
        else $error("ram block window wrong");

    AST_PD_STOP: assert property ( // [RULE9]
        state_reg == pmc_pkg::ST_PDOWN && !RST_PIN && !ext_low |->
        !OSC_EN && !PERIPH_CLK_EN && !CPU_CLK_EN)
        else $error("clocks running in power-down");

    AST_PD_HOLD: assert property ( // [RULE13]
        state_reg == pmc_pkg::ST_PDWK && ext_low && !RST_PIN |->
        OSC_EN && !CPU_CLK_EN ##1 !$fell(CPU_CLK_EN))
        else $error("execution resumed before release");

    AST_PD_STROBES: assert property ( // [RULE18]
        state_reg == pmc_pkg::ST_PDOWN &&
        $past(state_reg) == pmc_pkg::ST_PDOWN |->
        !ALE_OUT && !PROG_STORE_STROBE)
        else $error("strobes not low in power-down");

    AST_SEQ_CLEAR: assert property ( // [RULE17]
        CORE_RESET && !RST_PIN ##1 !CORE_RESET |->
        power_control_reg[3:0] == 4'h0)
        else $error("register not reinitialised");

    COV_IDLE_IRQ: cover property (
        state_reg == pmc_pkg::ST_IDLE ##1 state_reg == pmc_pkg::ST_RUN);
    COV_PD_EXT: cover property (
        state_reg == pmc_pkg::ST_PDWK ##1 state_reg == pmc_pkg::ST_RUN);
    COV_PD_RESET: cover property (
        state_reg == pmc_pkg::ST_PDOWN ##1 state_reg == pmc_pkg::ST_RLAG);

endmodule : pmc_top

`default_nettype wire

// file: tb/pmc_partner.sv
// core-side model: interrupt, wake line, reset pin and core pin values
// assumes bench requests change by non-blocking assignment on CLK rise
`default_nettype none
module pmc_partner (
    input  wire logic CLK,
    input  wire logic irq_req,
    input  wire logic line_req,
    input  wire logic rst_req,
    input  wire logic ext_code,
    output logic      RST_PIN,
    output logic      IRQ_PENDING,
    output logic      LINE_N,
    output logic      P0_OE_N
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // wake line: stays low long after release so the osc can settle
    // ----------------------------------------------------------------
    logic [3:0] hold_cnt = 4'h0;  // cycles still held after release
    always_ff @(posedge CLK) begin
        hold_cnt <= line_req ? 4'hF : hold_cnt - {3'h0, |hold_cnt};
    end
    assign LINE_N = !line_req && hold_cnt == 4'h0;
    assign IRQ_PENDING = irq_req;  // level, held until serviced
    assign RST_PIN = rst_req;
    // no port write after entry: port 0 only follows code source
    assign P0_OE_N = ext_code;
endmodule : pmc_partner
`default_nettype wire

// file: tb/power_mode_controller_bench.sv
// self-checking bench: register bus tasks and power mode sequences
// assumes pmc_pkg, pmc_top and pmc_partner are compiled first
`default_nettype none
module power_mode_controller_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // stimulus, observed nets, counters
    // ----------------------------------------------------------------
    logic CLK, SRST = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0;
    logic arv = 1'b0, rre = 1'b0, ext_code = 1'b1, irq_req = 1'b0;
    logic line_req = 1'b0, rst_req = 1'b0;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic [31:0] wd = 32'h0, rd_q;
    logic [3:0] ws = 4'hF;
    logic [1:0] resp;
    wire logic awr, wrr, bv, arr, rv, pin, irqp, ln, p0n, cpu, per, osc;
    wire logic ramb, crst, p0oe, pfh, ale, program_store_strobe, baud, sct;
    wire logic [1:0] brsp, rrsp;
    wire logic [31:0] rdat;
    wire logic [15:0] rvec;
    int failures = 0, checks_done = 0;
    pmc_top #(.LAG_CYCLES(4), .SEQ_CYCLES(2)) dut (.CLK(CLK), .SRST(SRST),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wrr), .S_AXI_BRESP(brsp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rrsp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .RST_PIN(pin),
        .IRQ_PENDING(irqp), .EXT_IRQ_LINE_A_N(ln), .EXT_IRQ_LINE_B_N(1'b1),
        .CPU_CLK_EN(cpu), .PERIPH_CLK_EN(per), .OSC_EN(osc),
        .RAM_BLOCK(ramb), .CORE_RESET(crst), .RESET_VECTOR(rvec),
        .EXT_CODE(ext_code), .CORE_P0_OE_N(p0n), .CORE_ALE(ext_code),
        .CORE_PROG_STROBE(ext_code), .PORT0_OE_N(p0oe),
        .PORTS_FORCE_HIGH(pfh),
        .ALE_OUT(ale), .PROG_STORE_STROBE(program_store_strobe), .SERIAL_MODE_TOP_IN(1'b1),
        .FRAME_ERROR_IN(1'b0), .BAUD_DOUBLE(baud), .SERIAL_CTRL_TOP(sct));
    pmc_partner core (.CLK(CLK), .irq_req(irq_req), .line_req(line_req),
        .rst_req(rst_req), .ext_code(ext_code), .RST_PIN(pin),
        .IRQ_PENDING(irqp), .LINE_N(ln), .P0_OE_N(p0n));
    // ----------------------------------------------------------------
    // tasks: compare, bus write and read, verdict
    // ----------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // address and data offered together, each dropped once taken
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic da, dw;
        da = 1'b0;
        dw = 1'b0;
        @(posedge CLK);
        {awa, wd, awv, wv, bre} <= {a, d, 3'b111};
        do begin
            @(negedge CLK);
            da = da | (awv & awr);
            dw = dw | (wv & wrr);
            @(posedge CLK);
            if (da) awv <= 1'b0;
            if (dw) wv <= 1'b0;
        end while (!(da && dw));
        do @(negedge CLK); while (bv !== 1'b1);
        resp = brsp;
        @(posedge CLK);
        bre <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] a);
        @(posedge CLK);
        {ara, arv, rre} <= {a, 2'b11};
        do @(negedge CLK); while (arr !== 1'b1);
        @(posedge CLK);
        arv <= 1'b0;
        do @(negedge CLK); while (rv !== 1'b1);
        {rd_q, resp} = {rdat, rrsp};
        @(posedge CLK);
        rre <= 1'b0;
    endtask : rd
    task close_out;
        if (failures == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    // ----------------------------------------------------------------
    // clock, watchdog, test sequence
    // ----------------------------------------------------------------
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        failures++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge CLK);
        SRST <= 1'b0;
        rd(pmc_pkg::POWER_CONTROL_ADDR);
        chk(rd_q, 32'h10);
        for (int i = 0; i < 2; i++) begin
            wr(pmc_pkg::POWER_CONTROL_ADDR, i ? 32'hC0 : 32'h00);
            @(negedge CLK);
            chk({28'h0, resp, baud, sct}, i ? 32'h2 : 32'h1);
        end
        @(posedge CLK);
        ws <= 4'hE;
        wr(pmc_pkg::POWER_CONTROL_ADDR, 32'h01);  // lane 0 off: ignored
        ws <= 4'hF;
        @(negedge CLK);
        chk({29'h0, resp, cpu}, 32'h1);
        rd(pmc_pkg::POWER_CONTROL_ADDR);
        chk(rd_q, 32'hC0);
        wr(pmc_pkg::POWER_CONTROL_ADDR, 32'h2D);  // idle, both flags, bit 5
        @(negedge CLK);
        chk({cpu,per,osc,ale,program_store_strobe,p0oe,pfh}, 32'h3E);
        @(posedge CLK);
        irq_req <= 1'b1;
        do @(negedge CLK); while (cpu !== 1'b1);
        @(posedge CLK);
        irq_req <= 1'b0;
        rd(pmc_pkg::POWER_CONTROL_ADDR);
        chk(rd_q, 32'h0C);
        ext_code <= 1'b0;  // internal code: port 0 holds data
        wr(pmc_pkg::POWER_CONTROL_ADDR, 32'h0B);  // both request bits
        @(negedge CLK);
        chk({cpu,per,osc,ale,program_store_strobe,p0oe}, 32'h0);
        @(posedge CLK);
        irq_req <= 1'b1;
        repeat (3) @(negedge CLK);
        chk({31'h0, osc}, 32'h0);
        @(posedge CLK);
        {irq_req, line_req} <= 2'b01;
        @(negedge CLK);
        chk({osc, cpu}, 32'h2);
        @(posedge CLK);
        line_req <= 1'b0;
        repeat (10) @(negedge CLK);
        chk({31'h0, cpu}, 32'h0);
        do @(negedge CLK); while (cpu !== 1'b1);
        repeat (3) @(negedge CLK);
        chk({31'h0, cpu}, 32'h1);
        rd(pmc_pkg::POWER_CONTROL_ADDR);
        chk(rd_q, 32'h08);
        wr(pmc_pkg::POWER_CONTROL_ADDR, 32'hFE);  // power-down, upper bits set
        rst_req <= 1'b1;
        @(negedge CLK);
        chk({31'h0, osc}, 32'h1);
        do @(negedge CLK); while (ramb !== 1'b1);
        chk({31'h0, crst}, 32'h0);
        do @(negedge CLK); while (crst !== 1'b1);
        chk({12'h0,ale,program_store_strobe,p0oe,pfh,rvec}, 32'hF0000);
        @(posedge CLK);
        rst_req <= 1'b0;
        do @(negedge CLK); while (crst !== 1'b0);
        rd(pmc_pkg::POWER_CONTROL_ADDR);
        chk(rd_q, 32'hD0);
        rd(12'h000);
        chk(rd_q, 32'h0);
        chk({30'h0, resp}, {30'h0, pmc_pkg::RESP_SLVERR});
        close_out();
    end
endmodule : power_mode_controller_bench
`default_nettype wire
